// file: verilog/afe_pkg.sv
// package for the converter front end: register map, field layouts, source codes, timing
// assumes one 200 MHz clock and an Avalon-MM slave with waitrequest
package afe_pkg;
   localparam int CLK_MHZ = 200;
   localparam int ADDR_W = 4;
   // register byte addresses
   localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] REG_TAP = 4'h4;
   localparam logic [ADDR_W-1:0] REG_TRIM = 4'h8;
   localparam logic [ADDR_W-1:0] REG_THRESH = 4'hc;
   // control fields
   localparam int CTRL_FMT_BIT = 0;
   localparam int CTRL_SLEEP_BIT = 1;
   localparam int CTRL_DITHER_BIT = 2;
   localparam int CTRL_SEL_LSB = 4;
   localparam int CTRL_OVL_BIT = 8;
   localparam int TRIM_GAIN_LSB = 16;
   // limits of the build settings
   localparam int TAP_MAX = 511;
   localparam int OFFSET_MAX = 32767;
   localparam int THRESH_MAX = 32767;
   localparam int STRETCH_MAX = 65535;
   localparam int GAIN_UNITY = 100;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
   // indicator source codes
   typedef enum logic [1:0]
   {
      AFE_SRC_RAW = 2'b00,
      AFE_SRC_TRIM = 2'b01,
      AFE_SRC_EXT = 2'b10,
      AFE_SRC_OFF = 2'b11
   } afe_src_e;
   // live settings carried from the register file to the data path
   typedef struct packed
   {
      logic fmt;
      afe_src_e sel;
      logic [8:0] tap;
      logic [15:0] gain;
      logic signed [15:0] offset;
      logic [14:0] thresh;
   } afe_cfg_s;
endpackage

// file: verilog/afe_tapline.sv
// tap delay line: sample memory with registered read data
// assumes one clock; the delay set by the tap count is counted in clock cycles, so it depends on the rate
`timescale 1ns/1ps
`default_nettype none
module afe_tapline #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 512
)(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // data
   input wire logic [WIDTH-1:0] din,
   input wire logic [$clog2(DEPTH)-1:0] taps,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [$clog2(DEPTH)-1:0] wr_q;
   logic [$clog2(DEPTH)-1:0] rd;

   // read one location behind by the tap count; zero taps still costs the read register
   assign rd = wr_q - taps;

   // write pointer
   always_ff @(posedge clk)
   begin
      if (srst)
         wr_q <= '0;
      else
         wr_q <= wr_q + 1'b1;
   end

   // memory write and registered read; write-first keeps zero taps meaningful
   always_ff @(posedge clk)
   begin
      mem[wr_q] <= din;
      if (rd == wr_q)
         dout <= din;
      else
         dout <= mem[rd];
   end
endmodule
`default_nettype wire

// file: verilog/afe_stretch.sv
// pulse stretcher for the overload indicator
// assumes one clock; stretch count is held steady by the caller
`timescale 1ns/1ps
`default_nettype none
module afe_stretch #(
   parameter int CW = 16
)(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // event in, stretched level out
   input wire logic ev,
   input wire logic [CW-1:0] len,
   output logic q
);
   logic [CW-1:0] cnt_q;

   // reload on every event, count down afterwards
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         cnt_q <= '0;
         q <= 1'b0;
      end
      else if (ev)
      begin
         cnt_q <= len;
         q <= 1'b1;
      end
      else if (cnt_q != '0)
      begin
         cnt_q <= cnt_q - 1'b1;
         q <= 1'b1;
      end
      else
         q <= 1'b0;
   end

   // the level holds len+1 cycles after the last event cycle
   property p_hold;
      @(posedge clk) disable iff (srst) ev |=> q;
   endproperty
   a_hold: assert property (p_hold) else $error("stretch output missed an event");
endmodule
`default_nettype wire

// file: verilog/afe_front_end.sv
// top of the converter capture front end: sample path, overload indicator, registers
// assumes converter samples already captured into I_CLK; software on Avalon-MM
// Function
// - tap delay at reset comes from a build parameter, 0 to 511 taps
// - offset trim at reset is a signed parameter, -32767 to 32767
// - format set converts offset binary samples to two's complement first
// - sleep parameter sets the power-down output level after reset, active when set
// - dither output is active high, reset level from the dither parameter
// - indicator source codes: 0 raw, 1 trim, 2 external, 3 off
// - overload threshold starts from a parameter, 0 to 32767
// - indicator output is stretched by a parameter, 0 to 65535
// - a build flag decides whether the external indicator input exists
// - gain stage scales samples by a percentage from a parameter
// - delay calibration reference frequency in MHz is a parameter, typically 200
// - overload flags when sample magnitude crosses the loaded threshold
// - output samples are 16-bit signed after rounding and saturation
// - overloads are reported on a dedicated indicator output
//
// The Avalon-MM interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module afe_front_end
   import afe_pkg::*;
#(
   parameter int INITIAL_TAP_DELAY = 0,
   parameter int INITIAL_GAIN_PERCENT = 100,
   parameter int INITIAL_OFFSET_COUNTS = 0,
   parameter bit RESET_SIGNED_FORMAT_ENABLE = 1'b1,
   parameter bit INITIAL_SLEEP = 1'b0,
   parameter bit INITIAL_DITHER = 1'b0,
   parameter int INITIAL_IND_SELECT = 0,
   parameter bit HAS_EXT_IND_SRC = 1'b1,
   parameter int REFCLK_FREQ_MHZ = 200,
   parameter int INITIAL_OVLD_THRESH = 32767,
   parameter int IND_PULSE_STRETCH = 0
)(
   // clock and reset
   input wire logic I_CLK,
   input wire logic I_SRST,
   // converter samples
   input wire logic [15:0] I_ADC_DATA,
   input wire logic I_EXT_IND,
   // converter controls
   output logic O_ADC_SLEEP,
   output logic O_ADC_DITHER,
   // sample stream
   output logic [15:0] O_TDATA,
   output logic O_TVALID,
   // indicator
   output logic O_OVLD_IND,
   // avalon-mm slave
   input wire logic [ADDR_W-1:0] I_AVS_ADDRESS,
   input wire logic I_AVS_READ,
   input wire logic I_AVS_WRITE,
   input wire logic [31:0] I_AVS_WRITEDATA,
   input wire logic [3:0] I_AVS_BYTEENABLE,
   output logic [31:0] O_AVS_READDATA,
   output logic O_AVS_WAITREQUEST
);
   ////////////////////////////////////////////////////////////////////////////
   // build-setting checks, fixed at elaboration
   localparam logic [8:0] RST_TAP = 9'(INITIAL_TAP_DELAY);
   localparam logic [15:0] RST_GAIN = 16'(INITIAL_GAIN_PERCENT);
   localparam logic [15:0] RST_OFFSET = 16'(INITIAL_OFFSET_COUNTS);
   localparam logic [14:0] RST_THRESH = 15'(INITIAL_OVLD_THRESH);
   localparam logic [15:0] STRETCH_LEN = 16'(IND_PULSE_STRETCH);
   localparam logic [1:0] RST_SEL = 2'(INITIAL_IND_SELECT);
   // calibration reference in MHz; the capture clock stands in for it here
   localparam int REF_MHZ = REFCLK_FREQ_MHZ;
   initial
   begin
      if (INITIAL_TAP_DELAY < 0 || INITIAL_TAP_DELAY > TAP_MAX) $error("tap delay out of range");
      if (INITIAL_OFFSET_COUNTS < -OFFSET_MAX || INITIAL_OFFSET_COUNTS > OFFSET_MAX) $error("offset out of range");
      if (INITIAL_OVLD_THRESH < 0 || INITIAL_OVLD_THRESH > THRESH_MAX) $error("threshold out of range");
      if (IND_PULSE_STRETCH < 0 || IND_PULSE_STRETCH > STRETCH_MAX) $error("stretch out of range");
      if (REF_MHZ != CLK_MHZ) $error("reference clock differs from capture clock");
   end

   ////////////////////////////////////////////////////////////////////////////
   // control registers
   afe_cfg_s cfg_q;
   logic sleep_q;
   logic dither_q;
   logic ovl_seen_q;
   logic ovl_ev;
   logic wr_en;

   assign wr_en = I_AVS_WRITE && !O_AVS_WAITREQUEST;

   // reset loads build settings; byte enables steer each byte written
   always_ff @(posedge I_CLK)
   begin
      if (I_SRST)
      begin
         cfg_q.fmt <= RESET_SIGNED_FORMAT_ENABLE;
         cfg_q.sel <= afe_src_e'(RST_SEL);
         cfg_q.tap <= RST_TAP;
         cfg_q.gain <= RST_GAIN;
         cfg_q.offset <= RST_OFFSET;
         cfg_q.thresh <= RST_THRESH;
         sleep_q <= INITIAL_SLEEP;
         dither_q <= INITIAL_DITHER;
      end
      else if (wr_en)
      begin
         case (I_AVS_ADDRESS)
            REG_CTRL:
            begin
               if (I_AVS_BYTEENABLE[0])
               begin
                  cfg_q.fmt <= I_AVS_WRITEDATA[CTRL_FMT_BIT];
                  sleep_q <= I_AVS_WRITEDATA[CTRL_SLEEP_BIT];
                  dither_q <= I_AVS_WRITEDATA[CTRL_DITHER_BIT];
                  cfg_q.sel <= afe_src_e'(I_AVS_WRITEDATA[CTRL_SEL_LSB +: 2]);
               end
            end
            REG_TAP:
            begin
               if (I_AVS_BYTEENABLE[0]) cfg_q.tap[7:0] <= I_AVS_WRITEDATA[7:0];
               if (I_AVS_BYTEENABLE[1]) cfg_q.tap[8] <= I_AVS_WRITEDATA[8];
            end
            REG_TRIM:
            begin
               if (I_AVS_BYTEENABLE[0]) cfg_q.offset[7:0] <= I_AVS_WRITEDATA[7:0];
               if (I_AVS_BYTEENABLE[1]) cfg_q.offset[15:8] <= I_AVS_WRITEDATA[15:8];
               if (I_AVS_BYTEENABLE[2]) cfg_q.gain[7:0] <= I_AVS_WRITEDATA[23:16];
               if (I_AVS_BYTEENABLE[3]) cfg_q.gain[15:8] <= I_AVS_WRITEDATA[31:24];
            end
            REG_THRESH:
            begin
               if (I_AVS_BYTEENABLE[0]) cfg_q.thresh[7:0] <= I_AVS_WRITEDATA[7:0];
               if (I_AVS_BYTEENABLE[1]) cfg_q.thresh[14:8] <= I_AVS_WRITEDATA[14:8];
            end
            default:
            begin
               cfg_q <= cfg_q;
            end
         endcase
      end
   end

   // sticky overload flag; a new event wins over the clear by write-one
   always_ff @(posedge I_CLK)
   begin
      if (I_SRST)
         ovl_seen_q <= 1'b0;
      else if (ovl_ev)
         ovl_seen_q <= 1'b1;
      else if (wr_en && I_AVS_ADDRESS == REG_CTRL && I_AVS_BYTEENABLE[1] && I_AVS_WRITEDATA[CTRL_OVL_BIT])
         ovl_seen_q <= 1'b0;
   end

   // converter control pins follow their registers one cycle later
   always_ff @(posedge I_CLK)
   begin
      if (I_SRST)
      begin
         O_ADC_SLEEP <= INITIAL_SLEEP;
         O_ADC_DITHER <= INITIAL_DITHER;
      end
      else
      begin
         O_ADC_SLEEP <= sleep_q;
         O_ADC_DITHER <= dither_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // avalon slave: one wait cycle, answer on the second cycle of the request
   logic busy_q;
   logic req;
   assign req = I_AVS_READ || I_AVS_WRITE;

   always_ff @(posedge I_CLK)
   begin
      if (I_SRST)
         busy_q <= 1'b0;
      else
         busy_q <= req && !busy_q;
   end

   // waitrequest idles high, drops for exactly the accepting cycle
   always_ff @(posedge I_CLK)
   begin
      if (I_SRST)
         O_AVS_WAITREQUEST <= 1'b1;
      else
         O_AVS_WAITREQUEST <= !(req && O_AVS_WAITREQUEST && !busy_q);
   end

   // read data registered in the same cycle waitrequest falls
   always_ff @(posedge I_CLK)
   begin
      if (I_SRST)
         O_AVS_READDATA <= '0;
      else if (I_AVS_READ)
      begin
         case (I_AVS_ADDRESS)
            REG_CTRL: O_AVS_READDATA <= {23'h0, ovl_seen_q, 2'h0, cfg_q.sel, 1'b0, dither_q, sleep_q, cfg_q.fmt};
            REG_TAP: O_AVS_READDATA <= {23'h0, cfg_q.tap};
            REG_TRIM: O_AVS_READDATA <= {cfg_q.gain, cfg_q.offset};
            REG_THRESH: O_AVS_READDATA <= {17'h0, cfg_q.thresh};
            default: O_AVS_READDATA <= UNMAPPED_DATA;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sample path: format, tap delay, gain and offset, saturate
   logic [15:0] fmt_q;
   logic [15:0] dly;
   logic signed [33:0] prod;
   logic signed [33:0] scaled_q;
   logic signed [33:0] sum;
   logic raw_ovl_q;
   logic raw_ovl_d1_q;
   logic trim_ovl;

   // offset-binary to two's complement is a flip of the sign bit
   always_ff @(posedge I_CLK)
   begin
      if (I_SRST)
         fmt_q <= '0;
      else
         fmt_q <= cfg_q.fmt ? {~I_ADC_DATA[15], I_ADC_DATA[14:0]} : I_ADC_DATA;
   end

   afe_tapline #(.WIDTH(16), .DEPTH(TAP_MAX + 1)) u_tap (
      .clk(I_CLK),
      .srst(I_SRST),
      .din(fmt_q),
      .taps(cfg_q.tap),
      .dout(dly)
   );

   // gain as percent: x*gain*655/65536 approximates x*gain/100
   assign prod = 34'(signed'(dly)) * signed'({18'h0, cfg_q.gain});

   always_ff @(posedge I_CLK)
   begin
      if (I_SRST)
         scaled_q <= '0;
      else
         scaled_q <= 34'((prod * 34'sd655 + 34'sd32768) >>> 16);
   end

   assign sum = scaled_q + 34'(cfg_q.offset);

   // rounding done above; clamp to 16-bit signed range
   always_ff @(posedge I_CLK)
   begin
      if (I_SRST)
      begin
         O_TDATA <= '0;
         O_TVALID <= 1'b0;
      end
      else
      begin
         O_TVALID <= 1'b1;
         if (sum > 34'sd32767)
            O_TDATA <= 16'h7fff;
         else if (sum < -34'sd32768)
            O_TDATA <= 16'h8000;
         else
            O_TDATA <= sum[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // overload detection and indicator selection
   logic [15:0] raw_mag;
   logic [33:0] trim_mag;
   logic ext_s1_q;
   logic ext_s2_q;
   logic ext_s3_q;
   logic ext_lvl_q;

   assign raw_mag = dly[15] ? 16'(-signed'(dly)) : dly;
   assign trim_mag = sum[33] ? 34'(-sum) : sum;
   assign trim_ovl = trim_mag > 34'(cfg_q.thresh);

   // raw check registered twice, so it lands one cycle after the trim check
   always_ff @(posedge I_CLK)
   begin
      if (I_SRST)
      begin
         raw_ovl_q <= 1'b0;
         raw_ovl_d1_q <= 1'b0;
      end
      else
      begin
         raw_ovl_q <= raw_mag > {1'b0, cfg_q.thresh};
         raw_ovl_d1_q <= raw_ovl_q;
      end
   end

   // external source is a pin: three flops, change accepted when second and third agree
   generate
      if (HAS_EXT_IND_SRC)
      begin : g_ext
         always_ff @(posedge I_CLK)
         begin
            if (I_SRST)
            begin
               ext_s1_q <= 1'b0;
               ext_s2_q <= 1'b0;
               ext_s3_q <= 1'b0;
               ext_lvl_q <= 1'b0;
            end
            else
            begin
               ext_s1_q <= I_EXT_IND;
               ext_s2_q <= ext_s1_q;
               ext_s3_q <= ext_s2_q;
               if (ext_s2_q == ext_s3_q)
                  ext_lvl_q <= ext_s3_q;
            end
         end
      end
      else
      begin : g_noext
         assign ext_s1_q = 1'b0;
         assign ext_s2_q = 1'b0;
         assign ext_s3_q = 1'b0;
         assign ext_lvl_q = 1'b0;
      end
   endgenerate

   always_comb
   begin
      case (cfg_q.sel)
         AFE_SRC_RAW: ovl_ev = raw_ovl_d1_q;
         AFE_SRC_TRIM: ovl_ev = trim_ovl;
         AFE_SRC_EXT: ovl_ev = ext_lvl_q;
         AFE_SRC_OFF: ovl_ev = 1'b0;
         default: ovl_ev = 1'b0;
      endcase
   end

   afe_stretch #(.CW(16)) u_str (
      .clk(I_CLK),
      .srst(I_SRST),
      .ev(ovl_ev),
      .len(STRETCH_LEN),
      .q(O_OVLD_IND)
   );

   ////////////////////////////////////////////////////////////////////////////
   // checks
   property p_rst_sleep;
      @(posedge I_CLK) $fell(I_SRST) |-> O_ADC_SLEEP == INITIAL_SLEEP;
   endproperty
   a_rst_sleep: assert property (p_rst_sleep) else $error("sleep pin not at reset level");

   property p_rst_dither;
      @(posedge I_CLK) $fell(I_SRST) |-> O_ADC_DITHER == INITIAL_DITHER;
   endproperty
   a_rst_dither: assert property (p_rst_dither) else $error("dither pin not at reset level");

   property p_rst_load;
      @(posedge I_CLK) $fell(I_SRST) |-> cfg_q.tap == RST_TAP && cfg_q.thresh == RST_THRESH && cfg_q.offset == RST_OFFSET;
   endproperty
   a_rst_load: assert property (p_rst_load) else $error("settings not loaded at reset");

   property p_sat;
      @(posedge I_CLK) disable iff (I_SRST) sum > 34'sd32767 |=> O_TDATA == 16'h7fff;
   endproperty
   a_sat: assert property (p_sat) else $error("positive saturation missed");

   property p_off;
      @(posedge I_CLK) disable iff (I_SRST) cfg_q.sel == AFE_SRC_OFF |-> !ovl_ev;
   endproperty
   a_off: assert property (p_off) else $error("disabled source still fires");

   property p_trim;
      @(posedge I_CLK) disable iff (I_SRST) cfg_q.sel == AFE_SRC_TRIM && trim_mag > 34'(cfg_q.thresh) |=> O_OVLD_IND;
   endproperty
   a_trim: assert property (p_trim) else $error("threshold crossing not shown");

   // a fresh request is answered on the next edge, and waitrequest stands low for that one edge only
   sequence s_new_req;
      req && O_AVS_WAITREQUEST && !busy_q;
   endsequence
   sequence s_acc;
      !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST;
   endsequence
   property p_bus;
      @(posedge I_CLK) disable iff (I_SRST) s_new_req |=> s_acc;
   endproperty
   a_bus: assert property (p_bus) else $error("bus answer late");

   property p_fmt;
      @(posedge I_CLK) disable iff (I_SRST) cfg_q.fmt && $stable(cfg_q.fmt) |=> fmt_q[15] == !$past(I_ADC_DATA[15]);
   endproperty
   a_fmt: assert property (p_fmt) else $error("format conversion wrong");
endmodule
`default_nettype wire

// file: sim/afe_adc_model.sv
// converter chip model: one offset binary sample per clock from a wanted level
// assumes the bench sets the level; the front end drives sleep and dither
`timescale 1ns/1ps
`default_nettype none
module afe_adc_model
   import afe_pkg::*;
(
   // clock
   input wire logic clk,
   // controls from the front end
   input wire logic sleep,
   input wire logic dither,
   // wanted level and converter output
   input wire logic [15:0] level,
   output logic [15:0] code
);
   ////////////////////////////////////////////////////////////////////////////////
   // asleep the chip gives no valid data, so the pins toggle instead of holding a value
   // dither only adds analog noise, which this model leaves out
   // no start value: sleep is still unknown at the first edge, so the level path fills the pins
   always_ff @(posedge clk)
   begin
      if (sleep)
         code <= ~code;
      else
         code <= level ^ 16'h8000;
   end
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// self-checking bench for the converter front end with a converter model
// assumes the avalon slave answers on its own; all waits are bounded
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import afe_pkg::*;
   localparam int STR = 20;
   typedef struct {logic [1:0] sel; int x; int y; logic ind;} afe_row_s;
   logic clk, srst, ext, av_rd, av_wr, sleep, dither, tvalid, ind, ind2, wreq, seen, seen2;
   logic [ADDR_W-1:0] av_addr;
   logic [31:0] av_wd, av_rdata, rd;
   logic [3:0] av_be;
   logic [15:0] level, adc, tdata, prev;
   int failures, comparisons, n, h;
   int lat_taps [3] = '{10, 0, 511};
   // threshold 1000, gain 100, offset -200: raw and trim sources disagree on purpose
   afe_row_s rows [8] = '{'{2'd0, 0, -200, 1'b0}, '{2'd0, 1000, 799, 1'b0}, '{2'd0, 1001, 800, 1'b1},
      '{2'd0, -1001, -1200, 1'b1}, '{2'd1, 1150, 949, 1'b0}, '{2'd1, -850, -1050, 1'b1},
      '{2'd3, -5000, -5197, 1'b0}, '{2'd1, 32767, 32549, 1'b1}};
   ////////////////////////////////////////////////////////////////////////////////
   // model, main front end and a second one without the external source, both on the same bus
   afe_adc_model afe_adc_model_i (.clk(clk), .sleep(sleep), .dither(dither), .level(level), .code(adc));
   afe_front_end #(.INITIAL_TAP_DELAY(3), .INITIAL_OFFSET_COUNTS(-200), .INITIAL_SLEEP(1'b1),
      .INITIAL_DITHER(1'b1), .INITIAL_IND_SELECT(1), .INITIAL_OVLD_THRESH(20000), .IND_PULSE_STRETCH(STR))
   afe_front_end_i (.I_CLK(clk), .I_SRST(srst), .I_ADC_DATA(adc), .I_EXT_IND(ext), .O_ADC_SLEEP(sleep),
      .O_ADC_DITHER(dither), .O_TDATA(tdata), .O_TVALID(tvalid), .O_OVLD_IND(ind), .I_AVS_ADDRESS(av_addr),
      .I_AVS_READ(av_rd), .I_AVS_WRITE(av_wr), .I_AVS_WRITEDATA(av_wd), .I_AVS_BYTEENABLE(av_be),
      .O_AVS_READDATA(av_rdata), .O_AVS_WAITREQUEST(wreq));
   afe_front_end #(.HAS_EXT_IND_SRC(1'b0), .INITIAL_IND_SELECT(2))
   afe_front_end_noext_i (.I_CLK(clk), .I_SRST(srst), .I_ADC_DATA(adc), .I_EXT_IND(ext), .O_ADC_SLEEP(),
      .O_ADC_DITHER(), .O_TDATA(), .O_TVALID(), .O_OVLD_IND(ind2), .I_AVS_ADDRESS(av_addr), .I_AVS_READ(av_rd),
      .I_AVS_WRITE(av_wr), .I_AVS_WRITEDATA(av_wd), .I_AVS_BYTEENABLE(av_be), .O_AVS_READDATA(),
      .O_AVS_WAITREQUEST());
   ////////////////////////////////////////////////////////////////////////////////
   // 200 mhz clock
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // one count of slack, since rounding order in the trim stage is left open
   task automatic near(input logic [15:0] got, input int exp);
      int d;
      d = int'($signed(got)) - exp;
      if (!$isunknown(got) && d <= 1 && d >= -1)
         comparisons++;
      else
         chk(32'(got), 32'(exp));
   endtask
   task automatic end_sim();
      if (failures == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // one avalon transfer; request held until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
      int k;
      k = 0;
      @(posedge clk);
      av_addr <= a;
      av_wd <= wd;
      av_wr <= wr;
      av_rd <= ~wr;
      // waitrequest is judged only at rising edges; the accepting edge also carries the read data
      do
      begin
         @(posedge clk);
         k++;
      end
      while (wreq !== 1'b0 && k < 20);
      if (wreq !== 1'b0)
      begin
         failures++;
         end_sim();
      end
      rd = av_rdata;
      av_rd <= 1'b0;
      av_wr <= 1'b0;
   endtask
   task automatic hold_reset();
      srst <= 1'b1;
      repeat (16) @(posedge clk);
      srst <= 1'b0;
   endtask
   // build settings seen in the registers and on the converter controls
   task automatic reset_regs();
      logic [31:0] exp [4];
      exp = '{32'h17, 32'h3, 32'h0064ff38, 32'h4e20};
      for (int i = 0; i < 4; i++)
      begin
         bus(1'b0, ADDR_W'(4 * i), 32'h0);
         chk(i == 0 ? rd & 32'hfffffeff : rd, exp[i]);
      end
      chk(sleep, 1'b1);
      chk(dither, 1'b1);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence: table rows first, then the awkward cases
   initial
   begin
      failures = 0;
      comparisons = 0;
      {srst, ext, av_rd, av_wr, av_addr, av_wd, av_be, level} = {1'b1, 39'h0, 4'hf, 16'h0};
      hold_reset();
      reset_regs();
      chk(tvalid, 1'b1);
      bus(1'b1, REG_CTRL, 32'h1);
      repeat (2) @(posedge clk);
      #1;
      chk({sleep, dither}, 2'b00);
      bus(1'b1, REG_THRESH, 32'd1000);
      foreach (rows[i])
      begin
         bus(1'b1, REG_CTRL, {26'h0, rows[i].sel, 4'h1});
         level <= 16'(rows[i].x);
         seen = 1'b0;
         for (int c = 0; c < 60; c++)
         begin
            @(posedge clk);
            if (c == 12)
               level <= 16'h0;
            #1;
            seen |= (ind === 1'b1);
            if (c == 12)
               near(tdata, rows[i].y);
         end
         chk(seen, rows[i].ind);
         chk(ind, 1'b0);
      end
      // plain binary input passes unconverted
      bus(1'b1, REG_CTRL, 32'h30);
      level <= 16'd1000;
      repeat (12) @(posedge clk);
      #1;
      near(tdata, -31950);
      // double gain drives both ends into saturation
      bus(1'b1, REG_CTRL, 32'h31);
      bus(1'b1, REG_TRIM, {16'd200, 16'h0});
      level <= 16'd30000;
      repeat (12) @(posedge clk);
      #1;
      near(tdata, 32767);
      bus(1'b1, REG_TRIM, {16'd200, 16'h0});
      level <= 16'(-30000);
      repeat (12) @(posedge clk);
      #1;
      near(tdata, -32768);
      bus(1'b1, REG_TRIM, 32'h0064ff38);
      // latency per tap count; long hold so no stale memory word shows first
      foreach (lat_taps[j])
      begin
         bus(1'b1, REG_TAP, 32'(lat_taps[j]));
         level <= 16'd100;
         repeat (530) @(posedge clk);
         level <= 16'hff9c;
         #1;
         prev = tdata;
         n = 0;
         do
         begin
            @(posedge clk);
            #1;
            n++;
         end
         while (tdata === prev && n < 600);
         chk(32'(n), 32'(5 + lat_taps[j]));
      end
      // single overload sample, then stretch length and sticky flag
      // zero taps first, or the lone sample would sit behind the long delay left by the latency cases
      bus(1'b1, REG_TAP, 32'h0);
      bus(1'b1, REG_CTRL, 32'h1);
      level <= 16'd2000;
      @(posedge clk);
      level <= 16'h0;
      n = 0;
      h = 0;
      while (ind !== 1'b1 && n < 30)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      while (ind === 1'b1 && h < 100)
      begin
         @(posedge clk);
         #1;
         h++;
      end
      chk(32'(h == STR || h == STR + 1), 32'h1);
      bus(1'b0, REG_CTRL, 32'h0);
      chk(rd[8], 1'b1);
      bus(1'b1, REG_CTRL, 32'h101);
      bus(1'b0, REG_CTRL, 32'h0);
      chk(rd[8], 1'b0);
      // external source, present on one instance and absent on the other
      bus(1'b1, REG_CTRL, 32'h21);
      ext <= 1'b1;
      {seen, seen2} = 2'b00;
      for (int c = 0; c < 30; c++)
      begin
         @(posedge clk);
         if (c == 3)
            ext <= 1'b0;
         #1;
         seen |= (ind === 1'b1);
         seen2 |= (ind2 !== 1'b0);
      end
      chk(seen, 1'b1);
      chk(seen2, 1'b0);
      // unmapped place reads zero and ignores writes
      bus(1'b1, 4'h6, 32'hffffffff);
      bus(1'b0, 4'h6, 32'h0);
      chk(rd, UNMAPPED_DATA);
      // second reset in mid-run restores every setting
      @(posedge clk);
      hold_reset();
      reset_regs();
      end_sim();
   end
endmodule
`default_nettype wire
